// >>> core/tcas_top.sv
// counter read, password check and signature fetch command handling
//
// Our own choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
module tcas_top import tcas_pkg::*; #(
	parameter logic [255:0] SIG_VALUE = {8{32'h5a5aa5a5}} // arbitrary value
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// contactless link
	input wire logic link_clk,
	input wire logic link_rx_data,
	input wire logic link_rx_frame,
	output logic link_tx_data,
	output logic link_tx_frame
);
	tcas_crc_if rx_crc ();
	tcas_crc_if tx_crc ();
	tcas_crc u_rx_crc (.hclk(hclk), .hresetn(hresetn), .bus(rx_crc));
	tcas_crc u_tx_crc (.hclk(hclk), .hresetn(hresetn), .bus(tx_crc));

	logic [2:0] lvl;
	tcas_sync #(.W(3)) u_sync (.clk(hclk), .rst_n(hresetn),
		.pin({link_clk, link_rx_frame, link_rx_data}), .level(lvl));

	tcas_state_e st_q;
	tcas_kind_e kind_q;
	tcas_kind_e kind_d;
	logic clk_prev_q;
	logic frm_prev_q;
	logic rise;
	logic frm_fall;
	logic [2:0] rx_bit_q;
	logic [7:0] rx_sh_q;
	logic [3:0] rx_cnt_q;
	logic [7:0] rx_buf_q [7];
	logic decide;
	logic crc_ok;
	logic good_cnt;
	logic good_sig;
	logic good_pwd;
	logic pwd_match;
	logic locked;
	logic fail_step;
	logic [15:0] wait_q;
	logic [5:0] tx_len_q;
	logic [5:0] tx_idx_q;
	logic [2:0] tx_bit_q;
	logic tx_fin_q;
	logic [7:0] tx_byte;
	logic [2:0] last_bit;
	logic tx_q;
	logic tx_frm_q;
	// configuration and state
	logic cnt_guard_q;
	logic protect_level_q;
	logic [2:0] fail_limit_q;
	logic [7:0] start_page_q;
	logic [31:0] pwd_q;
	logic [15:0] ack_value_q;
	logic [23:0] cnt_q;
	logic auth_q;
	logic [2:0] fail_q;
	logic [8:0] page_req_q;
	logic page_ok;
	// bus
	logic wr_pend_q;
	logic [7:0] waddr_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;

	assign rise = lvl[2] & ~clk_prev_q;
	assign frm_fall = frm_prev_q & ~lvl[1];
	assign decide = (st_q == ST_RX) && frm_fall && (rx_cnt_q != 4'h0);
	assign crc_ok = (rx_crc.crc == 16'h0000);

	// receive: bits lsb first on link clock rises
	assign rx_crc.init = (st_q == ST_RX) && lvl[1] && !frm_prev_q;
	assign rx_crc.en = (st_q == ST_RX) && rise && lvl[1] && (rx_bit_q == 3'd7);
	assign rx_crc.data = {lvl[0], rx_sh_q[7:1]};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clk_prev_q <= 1'b0;
			frm_prev_q <= 1'b0;
		end else begin
			clk_prev_q <= lvl[2];
			frm_prev_q <= lvl[1];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_bit_q <= 3'd0;
			rx_sh_q <= 8'h00;
			rx_cnt_q <= 4'h0;
			for (int i = 0; i < 7; i++) rx_buf_q[i] <= 8'h00;
		end else if (rx_crc.init) begin
			rx_bit_q <= 3'd0;
			rx_cnt_q <= 4'h0;
		end else if (rx_crc.en) begin
			rx_bit_q <= 3'd0;
			if (rx_cnt_q < 4'h7) rx_buf_q[rx_cnt_q[2:0]] <= rx_crc.data;
			if (rx_cnt_q != 4'hf) rx_cnt_q <= rx_cnt_q + 4'h1;
		end else if ((st_q == ST_RX) && rise && lvl[1]) begin
			rx_sh_q <= {lvl[0], rx_sh_q[7:1]};
			rx_bit_q <= rx_bit_q + 3'd1;
		end
	end

	// decoding of the finished request
	assign good_cnt = crc_ok && (rx_cnt_q == LEN_SHORT_REQ) && (rx_buf_q[0] == COUNTER_READ_CMD)
		&& (rx_buf_q[1] == COUNTER_ARG);
	assign good_sig = crc_ok && (rx_cnt_q == LEN_SHORT_REQ) && (rx_buf_q[0] == SIGNATURE_FETCH_CMD)
		&& (rx_buf_q[1] == SIGNATURE_ARG);
	assign good_pwd = crc_ok && (rx_cnt_q == LEN_PWD_REQ) && (rx_buf_q[0] == PASSWORD_CHECK_CMD);
	assign pwd_match = ({rx_buf_q[4], rx_buf_q[3], rx_buf_q[2], rx_buf_q[1]} == pwd_q);
	assign locked = (fail_limit_q != 3'd0) && (fail_q >= fail_limit_q);
	assign fail_step = decide && good_pwd && !pwd_match && (fail_limit_q != 3'd0)
		&& (fail_q < fail_limit_q);

	always_comb begin
		kind_d = K_NAK;
		if (good_cnt) begin
			kind_d = (cnt_guard_q && !auth_q) ? K_NAK : K_CNT;
		end else if (good_sig) begin
			kind_d = K_SIG;
		end else if (good_pwd && pwd_match && !locked) begin
			kind_d = K_ACK;
		end
	end

	// session state: only field loss (reset) ends an authentication
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			auth_q <= 1'b0;
		end else if (decide && good_pwd && pwd_match && !locked) begin
			auth_q <= 1'b1;
		end
	end

	// failed attempts committed before the reply goes out
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fail_q <= 3'd0;
		end else if (fail_step) begin
			fail_q <= fail_q + 3'd1;
		end
	end

	// sequencing: receive, hold off the frame delay, send
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= ST_RX;
			kind_q <= K_NAK;
			wait_q <= 16'h0000;
			tx_len_q <= 6'h00;
		end else begin
			unique case (st_q)
				ST_RX: begin
					if (decide) begin
						st_q <= ST_WAIT;
						kind_q <= kind_d;
						wait_q <= 16'h0000;
						unique case (kind_d)
							K_NAK: tx_len_q <= LEN_NAK_RSP;
							K_CNT: tx_len_q <= LEN_CNT_RSP;
							K_ACK: tx_len_q <= LEN_ACK_RSP;
							K_SIG: tx_len_q <= LEN_SIG_RSP;
						endcase
					end
				end
				ST_WAIT: begin
					if (wait_q < 16'(FDT_CYC)) begin
						wait_q <= wait_q + 16'h0001;
					end else begin
						st_q <= ST_TX;
					end
				end
				ST_TX: begin
					if (rise && tx_fin_q) st_q <= ST_RX;
				end
				default: st_q <= ST_RX;
			endcase
		end
	end

	// reply byte: payload lsb first, then crc low and high
	always_comb begin
		tx_byte = 8'h00;
		if (kind_q == K_NAK) begin
			tx_byte = {4'h0, NAK_CODE};
		end else if (tx_idx_q == tx_len_q - 6'd2) begin
			tx_byte = tx_crc.crc[7:0];
		end else if (tx_idx_q == tx_len_q - 6'd1) begin
			tx_byte = tx_crc.crc[15:8];
		end else begin
			unique case (kind_q)
				K_CNT: tx_byte = 8'(cnt_q >> {tx_idx_q, 3'b000});
				K_ACK: tx_byte = 8'(ack_value_q >> {tx_idx_q, 3'b000});
				K_SIG: tx_byte = 8'(SIG_VALUE >> {tx_idx_q, 3'b000});
				default: tx_byte = 8'h00;
			endcase
		end
	end
	assign last_bit = (kind_q == K_NAK) ? 3'd3 : 3'd7;
	assign tx_crc.init = decide;
	assign tx_crc.en = (st_q == ST_TX) && rise && !tx_fin_q && (tx_bit_q == 3'd7)
		&& (tx_idx_q < tx_len_q - 6'd2);
	assign tx_crc.data = tx_byte;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_idx_q <= 6'h00;
			tx_bit_q <= 3'd0;
			tx_fin_q <= 1'b0;
			tx_q <= 1'b0;
			tx_frm_q <= 1'b0;
		end else if (st_q != ST_TX) begin
			tx_idx_q <= 6'h00;
			tx_bit_q <= 3'd0;
			tx_fin_q <= 1'b0;
		end else if (rise) begin
			if (tx_fin_q) begin
				tx_frm_q <= 1'b0;
				tx_q <= 1'b0;
			end else begin
				tx_frm_q <= 1'b1;
				tx_q <= tx_byte[tx_bit_q];
				tx_bit_q <= (tx_bit_q == last_bit) ? 3'd0 : tx_bit_q + 3'd1;
				if (tx_bit_q == last_bit) begin
					tx_idx_q <= tx_idx_q + 6'd1;
					tx_fin_q <= (tx_idx_q == tx_len_q - 6'd1);
				end
			end
		end
	end
	assign link_tx_data = tx_q;
	assign link_tx_frame = tx_frm_q;

	// page access check for the memory side
	always_comb begin
		page_ok = 1'b1;
		if ((page_req_q[7:0] >= start_page_q) && (page_req_q[PAGE_WRITE_BIT] || protect_level_q)) begin
			page_ok = auth_q && !locked;
		end
	end

	// ahb-lite: zero wait, always okay; read data captured in the address phase
	always_comb begin
		rdata_d = 32'h00000000;
		unique case (haddr[7:0])
			OFS_CONFIG: rdata_d = {16'h0000, start_page_q, 3'b000, fail_limit_q, protect_level_q, cnt_guard_q};
			OFS_ACK_VALUE: rdata_d = {16'h0000, ack_value_q};
			OFS_COUNTER: rdata_d = {8'h00, cnt_q};
			OFS_STATUS: rdata_d = {24'h000000, st_q, 1'b0, fail_q, locked, auth_q};
			OFS_PAGE_CHECK: rdata_d = {22'h0, page_req_q, page_ok};
			default: rdata_d = 32'h00000000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			waddr_q <= 8'h00;
			rdata_q <= 32'h00000000;
		end else if (hready) begin
			wr_pend_q <= hsel && htrans[1] && hwrite;
			waddr_q <= haddr[7:0];
			if (hsel && htrans[1] && !hwrite) rdata_q <= rdata_d;
		end
	end

	// password never reads back; counter write only steps it forward
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_guard_q <= 1'b0;
			protect_level_q <= 1'b0;
			fail_limit_q <= 3'd0;
			start_page_q <= START_PAGE_RST;
			pwd_q <= PASSWORD_RST;
			ack_value_q <= ACK_VALUE_RST;
			cnt_q <= 24'h000000;
			page_req_q <= 9'h000;
		end else if (wr_pend_q) begin
			unique case (waddr_q)
				OFS_CONFIG: begin
					cnt_guard_q <= hwdata[CFG_GUARD_BIT];
					protect_level_q <= hwdata[CFG_LEVEL_BIT];
					fail_limit_q <= hwdata[CFG_LIMIT_LSB +: 3];
					start_page_q <= hwdata[CFG_START_LSB +: 8];
				end
				OFS_PASSWORD: pwd_q <= hwdata;
				OFS_ACK_VALUE: ack_value_q <= hwdata[15:0];
				OFS_COUNTER: if (cnt_q != COUNTER_MAX) cnt_q <= cnt_q + 24'h000001;
				OFS_PAGE_CHECK: page_req_q <= hwdata[8:0];
				default: ;
			endcase
		end
	end
	assign hrdata = rdata_q;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// checks
	logic [15:0] gap_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) gap_q <= 16'h0000;
		else if (decide) gap_q <= 16'h0000;
		else if (gap_q != 16'hffff) gap_q <= gap_q + 16'h0001;
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_guarded_cnt;
		decide && good_cnt && cnt_guard_q;
	endsequence
	sequence s_bad_pwd;
		decide && good_pwd && !pwd_match;
	endsequence

	property p_fdt;
		$rose(link_tx_frame) |-> (gap_q >= 16'(FDT_CYC));
	endproperty
	a_fdt: assert property (p_fdt) else $error("reply started before frame delay");
	property p_cnt_nak;
		s_guarded_cnt ##0 !auth_q |=> (kind_q == K_NAK) && (tx_len_q == LEN_NAK_RSP);
	endproperty
	a_cnt_nak: assert property (p_cnt_nak) else $error("guarded counter read not refused");
	property p_cnt_ok;
		s_guarded_cnt ##0 auth_q |=> (kind_q == K_CNT);
	endproperty
	a_cnt_ok: assert property (p_cnt_ok) else $error("authenticated counter read refused");
	property p_cnt_len;
		decide && good_cnt && !cnt_guard_q |=> (tx_len_q == LEN_CNT_RSP) && (st_q == ST_WAIT);
	endproperty
	a_cnt_len: assert property (p_cnt_len) else $error("counter reply length wrong");
	property p_auth_ok;
		decide && good_pwd && pwd_match && !locked |=> auth_q && (kind_q == K_ACK) && (tx_len_q == LEN_ACK_RSP);
	endproperty
	a_auth_ok: assert property (p_auth_ok) else $error("matching password not accepted");
	property p_auth_bad;
		s_bad_pwd ##0 !auth_q |=> !auth_q && (kind_q == K_NAK);
	endproperty
	a_auth_bad: assert property (p_auth_bad) else $error("wrong password accepted");
	property p_fail_cnt;
		fail_step |=> (fail_q == $past(fail_q) + 3'd1) ##1 (fail_q <= fail_limit_q);
	endproperty
	a_fail_cnt: assert property (p_fail_cnt) else $error("failed attempt not counted");
	property p_lockout;
		locked && (page_req_q[7:0] >= start_page_q) && page_req_q[PAGE_WRITE_BIT] |-> !page_ok;
	endproperty
	a_lockout: assert property (p_lockout) else $error("protected access after lockout");
	property p_read_guard;
		!auth_q && protect_level_q && (page_req_q[7:0] >= start_page_q) |-> !page_ok;
	endproperty
	a_read_guard: assert property (p_read_guard) else $error("protected read allowed");
	property p_sig_len;
		decide && good_sig |=> (kind_q == K_SIG) && (tx_len_q == LEN_SIG_RSP);
	endproperty
	a_sig_len: assert property (p_sig_len) else $error("signature reply wrong");
endmodule : tcas_top

// >>> core/tcas_pkg.sv
// constants and types shared by the tag command block
package tcas_pkg;
	// reader commands and their fixed argument bytes
	localparam logic [7:0] COUNTER_READ_CMD = 8'h39;
	localparam logic [7:0] PASSWORD_CHECK_CMD = 8'h1b;
	localparam logic [7:0] SIGNATURE_FETCH_CMD = 8'h3c;
	localparam logic [7:0] COUNTER_ARG = 8'h02;
	localparam logic [7:0] SIGNATURE_ARG = 8'h00;
	// request lengths in bytes, trailing crc included
	localparam logic [3:0] LEN_SHORT_REQ = 4'h4;
	localparam logic [3:0] LEN_PWD_REQ = 4'h7;
	// 4-bit negative acknowledge code
	localparam logic [3:0] NAK_CODE = 4'h0;
	// response lengths in bytes, trailing crc included; the nak is one 4-bit code without crc
	localparam logic [5:0] LEN_CNT_RSP = 6'h05;
	localparam logic [5:0] LEN_ACK_RSP = 6'h04;
	localparam logic [5:0] LEN_SIG_RSP = 6'h22;
	localparam logic [5:0] LEN_NAK_RSP = 6'h01;
	// crc of the contactless frames, lsb first
	localparam logic [15:0] CRC_INIT = 16'h6363;
	localparam logic [15:0] CRC_POLY = 16'h8408;
	// least frame delay: n=9 gives 9*128+84 carrier periods
	localparam int FDT_N = 9;
	localparam int FDT_CARRIER = FDT_N * 128 + 84;
	localparam int CARRIER_KHZ = 13560;
	localparam int CLK_KHZ = 40000;
	localparam int FDT_CYC = (FDT_CARRIER * CLK_KHZ + CARRIER_KHZ - 1) / CARRIER_KHZ;
	// register byte offsets
	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_PASSWORD = 8'h04;
	localparam logic [7:0] OFS_ACK_VALUE = 8'h08;
	localparam logic [7:0] OFS_COUNTER = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_PAGE_CHECK = 8'h14;
	// config fields
	localparam int CFG_GUARD_BIT = 0;
	localparam int CFG_LEVEL_BIT = 1;
	localparam int CFG_LIMIT_LSB = 2;
	localparam int CFG_START_LSB = 8;
	localparam int PAGE_WRITE_BIT = 8;
	// reset values, counter maximum and enum types
	localparam logic [31:0] PASSWORD_RST = 32'hffffffff;
	localparam logic [15:0] ACK_VALUE_RST = 16'h0000;
	localparam logic [7:0] START_PAGE_RST = 8'hff;
	localparam logic [23:0] COUNTER_MAX = 24'hffffff;
	typedef enum logic [1:0] {ST_RX = 2'b00, ST_WAIT = 2'b01, ST_TX = 2'b10} tcas_state_e;
	typedef enum logic [1:0] {K_NAK = 2'b00, K_CNT = 2'b01, K_ACK = 2'b10, K_SIG = 2'b11} tcas_kind_e;
endpackage : tcas_pkg

// >>> core/tcas_crc_if.sv
// byte stream into a crc engine and its running value
`timescale 1ns/1ps
interface tcas_crc_if;
	logic init;
	logic en;
	logic [7:0] data;
	logic [15:0] crc;
	modport src (output init, output en, output data, input crc);
	modport eng (input init, input en, input data, output crc);
endinterface : tcas_crc_if

// >>> core/tcas_sync.sv
// three-stage synchroniser, a change counts once stages two and three agree
`timescale 1ns/1ps
module tcas_sync import tcas_pkg::*; #(
	parameter int W = 3
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// pins and filtered levels
	input wire logic [W-1:0] pin,
	output logic [W-1:0] level
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] lvl_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			lvl_q <= '0;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			lvl_q <= (s2_q & ~(s2_q ^ s3_q)) | (lvl_q & (s2_q ^ s3_q));
		end
	end
	assign level = lvl_q;
endmodule : tcas_sync

// >>> core/tcas_crc.sv
// bytewise crc engine for link frames
`timescale 1ns/1ps
module tcas_crc import tcas_pkg::*; (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// byte stream
	tcas_crc_if.eng bus
);
	logic [15:0] crc_q;
	logic [15:0] crc_d;

	always_comb begin
		crc_d = crc_q ^ {8'h00, bus.data};
		for (int i = 0; i < 8; i++) begin
			crc_d = crc_d[0] ? ((crc_d >> 1) ^ CRC_POLY) : (crc_d >> 1);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			crc_q <= CRC_INIT;
		end else if (bus.init) begin
			crc_q <= CRC_INIT;
		end else if (bus.en) begin
			crc_q <= crc_d;
		end
	end
	assign bus.crc = crc_q;
endmodule : tcas_crc

// >>> dv/tcas_reader.sv
// reader model: sends request frames and collects the tag's reply bits
`timescale 1ns/1ps
module tcas_reader import tcas_pkg::*; (
	// link toward the tag
	output logic link_clk,
	output logic link_rx_data,
	output logic link_rx_frame,
	// reply from the tag
	input wire logic link_tx_data,
	input wire logic link_tx_frame
);
	logic run;
	logic [279:0] rsp_bits;
	int rsp_n;
	realtime t_end;
	realtime t_rsp;
	initial begin
		run = 1'b0;
		link_clk = 1'b0;
		link_rx_data = 1'b0;
		link_rx_frame = 1'b0;
		t_end = 0;
		t_rsp = 0;
		// offset keeps link edges clear of the system clock edges
		#7;
		forever #100 link_clk = run ? ~link_clk : 1'b0;
	end
	always @(posedge link_tx_frame) t_rsp = $realtime;
	task xfer(input logic [55:0] req, input int n);
		int i;
		rsp_bits = '0;
		rsp_n = 0;
		run = 1'b1;
		for (i = 0; i < n * 8; i++) begin
			@(negedge link_clk);
			link_rx_frame = 1'b1;
			link_rx_data = req[i];
		end
		@(negedge link_clk);
		link_rx_frame = 1'b0;
		// released line shows the inverse, never a stale bit
		link_rx_data = ~link_rx_data;
		t_end = $realtime;
		// give up after 5 ms of silence or once the reply frame ends
		for (i = 0; i < 25000; i++) begin
			@(posedge link_clk);
			if (link_tx_frame === 1'b1 && rsp_n < 280) begin
				rsp_bits[rsp_n] = link_tx_data;
				rsp_n++;
			end else if (rsp_n > 0) begin
				break;
			end
		end
		run = 1'b0;
	endtask : xfer
endmodule : tcas_reader

// >>> dv/tcas_top_test.sv
// self-checking bench for the tag command block
`timescale 1ns/1ps
module tcas_top_test import tcas_pkg::*; ;
	// arbitrary signature contents
	localparam logic [255:0] SIG_VAL = {4{64'h0123456789abcdef}};
	localparam logic [271:0] CNT_REQ = 272'({COUNTER_ARG, COUNTER_READ_CMD});
	localparam logic [271:0] SIG_REQ = 272'({SIGNATURE_ARG, SIGNATURE_FETCH_CMD});
	localparam logic [279:0] NAK = 280'(NAK_CODE);
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = '0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic link_clk, link_rx_data, link_rx_frame, link_tx_data, link_tx_frame;
	int bad_count = 0;
	int checks_done = 0;
	always #12.5 hclk = ~hclk;
	tcas_top #(.SIG_VALUE(SIG_VAL)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link_clk(link_clk),
		.link_rx_data(link_rx_data), .link_rx_frame(link_rx_frame), .link_tx_data(link_tx_data),
		.link_tx_frame(link_tx_frame));
	tcas_reader rdr (.link_clk(link_clk), .link_rx_data(link_rx_data), .link_rx_frame(link_rx_frame),
		.link_tx_data(link_tx_data), .link_tx_frame(link_tx_frame));
	task finish_test;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : finish_test
	task check(input logic [279:0] got, input logic [279:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : check
	task do_reset;
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		// let the link synchroniser fill
		repeat (6) @(posedge hclk);
	endtask : do_reset
	task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask : ahb
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		ahb(1'b1, a, d, dummy);
	endtask : wr
	task chk_reg(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] got;
		ahb(1'b0, a, 32'h0, got);
		check(280'(got), 280'(exp));
		check(280'(hresp), 280'(0));
	endtask : chk_reg
	// page check: request echoed in bits 9:1, grant in bit 0
	task page(input logic [7:0] pg, input logic w, input logic g);
		wr(OFS_PAGE_CHECK, {23'h0, w, pg});
		chk_reg(OFS_PAGE_CHECK, {22'h0, w, pg, g});
	endtask : page
	function automatic logic [15:0] crc_a(input logic [271:0] d, input int nb);
		logic [15:0] c;
		int i;
		int j;
		c = CRC_INIT;
		for (i = 0; i < nb; i++) begin
			c = c ^ {8'h00, d[i*8+:8]};
			for (j = 0; j < 8; j++) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction : crc_a
	// bytes lsb first, crc low byte then high byte appended
	function automatic logic [279:0] ok(input logic [271:0] d, input int nb);
		return {8'h00, d} | (280'(crc_a(d, nb)) << (nb * 8));
	endfunction : ok
	function automatic logic [271:0] pwd(input logic [31:0] p);
		return 272'({p, PASSWORD_CHECK_CMD});
	endfunction : pwd
	task run_cmd(input logic [271:0] d, input int nb, input logic [279:0] exp, input int exp_n);
		rdr.xfer(56'(ok(d, nb)), nb + 2);
		check(280'(rdr.rsp_n), 280'(exp_n));
		check(rdr.rsp_bits, exp);
		if (exp_n > 0) check(280'(rdr.t_rsp - rdr.t_end >= FDT_CYC * 25.0), 280'(1));
	endtask : run_cmd
	initial begin
		// whole sequence needs about 1.3 ms
		#2000000;
		bad_count++;
		finish_test;
	end
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (6) @(posedge hclk);
		chk_reg(OFS_CONFIG, 32'h0000ff00);
		chk_reg(OFS_PASSWORD, 32'h0);
		wr(OFS_COUNTER, 32'h0);
		wr(OFS_COUNTER, 32'h0);
		chk_reg(OFS_COUNTER, 32'h2);
		run_cmd(CNT_REQ, 2, ok(272'(24'h2), 3), 40);
		run_cmd(272'({8'h01, COUNTER_READ_CMD}), 2, NAK, 4);
		run_cmd(SIG_REQ, 2, ok(272'(SIG_VAL), 32), 272);
		run_cmd(pwd(32'h0), 5, NAK, 4);
		chk_reg(OFS_STATUS, 32'h0);
		wr(OFS_PASSWORD, 32'h11223344);
		wr(OFS_ACK_VALUE, 32'h0000beef);
		chk_reg(OFS_ACK_VALUE, 32'h0000beef);
		wr(OFS_CONFIG, 32'h0000100b);
		run_cmd(CNT_REQ, 2, NAK, 4);
		page(8'h10, 1'b0, 1'b0);
		page(8'h0f, 1'b0, 1'b1);
		run_cmd(pwd(32'h11223345), 5, NAK, 4);
		chk_reg(OFS_STATUS, 32'h4);
		run_cmd(pwd(32'h11223344), 5, ok(272'(16'hbeef), 2), 32);
		chk_reg(OFS_STATUS, 32'h5);
		run_cmd(CNT_REQ, 2, ok(272'(24'h2), 3), 40);
		page(8'h10, 1'b1, 1'b1);
		run_cmd(SIG_REQ, 2, ok(272'(SIG_VAL), 32), 272);
		do_reset;
		wr(OFS_CONFIG, 32'h00002008);
		run_cmd(pwd(32'h1), 5, NAK, 4);
		run_cmd(pwd(32'h2), 5, NAK, 4);
		chk_reg(OFS_STATUS, 32'ha);
		run_cmd(pwd(PASSWORD_RST), 5, NAK, 4);
		page(8'h20, 1'b0, 1'b1);
		page(8'h20, 1'b1, 1'b0);
		finish_test;
	end
endmodule : tcas_top_test
